/* core/irx_regs.sv */
// Isochronous receive interrupt event and mask registers behind an AHB-Lite slave
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Completed input command with interrupt sets event
// - Set on rising edge or write-one-set
// - Only write-one to clear address clears
// - Clear address read returns events with mask
// - Bits 31 to 4 read zero, except mask in bits 11 to 8 on clear address read and enable in bit 31
// - Event n marks context n as source
// - Per-context mask, write-one set and clear
// - Both mask addresses read the mask
// - Mask bit aligns with its event bit
// - Events stay set after reporting
// - Global enable off blocks external interrupt
module irx_regs
  import irx_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [IRX_CTX-1:0] ctxIrq,
  output logic aggregateReceiveInterrupt,
  output logic irq
);

  irx_req_t req;
  irx_req_t next_req;
  logic [IRX_CTX-1:0] ctxIrqPrev;
  logic [IRX_CTX-1:0] rxEvent;
  logic [IRX_CTX-1:0] mask;
  logic globalInterruptEnable;
  logic [IRX_CTX-1:0] next_rxEvent;
  logic [IRX_CTX-1:0] next_mask;
  logic next_gie;
  logic [31:0] next_hrdata;
  logic next_agg;
  logic next_irq;
  logic [IRX_CTX-1:0] ctxRise;
  logic wrEvtSet;
  logic wrEvtClr;
  logic wrMskSet;
  logic wrMskClr;
  logic wrGie;

  // Address phase capture; only whole-word nonsequential transfers are taken
  always_comb begin
    next_req.sel = hsel && hready && (htrans == IRX_HTRANS_NONSEQ) && (hsize == IRX_HSIZE_WORD);
    next_req.write = hwrite;
    next_req.addr = haddr[7:0];
  end

  // Context interrupt lines come from logic on this clock: edge found directly
  assign ctxRise = ctxIrq & ~ctxIrqPrev;

  assign wrEvtSet = req.sel && req.write && (req.addr == IRX_EVT_SET_OFS);
  assign wrEvtClr = req.sel && req.write && (req.addr == IRX_EVT_CLR_OFS);
  assign wrMskSet = req.sel && req.write && (req.addr == IRX_MSK_SET_OFS);
  assign wrMskClr = req.sel && req.write && (req.addr == IRX_MSK_CLR_OFS);
  assign wrGie = req.sel && req.write && (req.addr == IRX_GIE_OFS);

  always_comb begin
    next_rxEvent = rxEvent;
    if (wrEvtClr) begin
      next_rxEvent = next_rxEvent & ~hwdata[IRX_CTX-1:0];
    end
    // Set applied after clear so a same-cycle event is never lost
    next_rxEvent = next_rxEvent | ctxRise;
    if (wrEvtSet) begin
      next_rxEvent = next_rxEvent | hwdata[IRX_CTX-1:0];
    end
    next_mask = mask;
    if (wrMskSet) begin
      next_mask = next_mask | hwdata[IRX_CTX-1:0];
    end
    if (wrMskClr) begin
      next_mask = next_mask & ~hwdata[IRX_CTX-1:0];
    end
    next_gie = wrGie ? hwdata[IRX_GIE_BIT] : globalInterruptEnable;
    next_agg = |(next_rxEvent & next_mask);
    next_irq = next_agg && next_gie;
  end

  // Read data for the address phase now being accepted
  always_comb begin
    next_hrdata = 32'h0000_0000;
    if (next_req.sel && !next_req.write) begin
      case (next_req.addr)
        IRX_EVT_SET_OFS: next_hrdata[IRX_CTX-1:0] = next_rxEvent;
        IRX_EVT_CLR_OFS: begin
          next_hrdata[IRX_CTX-1:0] = next_rxEvent;
          next_hrdata[IRX_MSK_RD_LSB +: IRX_CTX] = next_mask;
        end
        IRX_MSK_SET_OFS: next_hrdata[IRX_CTX-1:0] = next_mask;
        IRX_MSK_CLR_OFS: next_hrdata[IRX_CTX-1:0] = next_mask;
        IRX_GIE_OFS: next_hrdata[IRX_GIE_BIT] = next_gie;
        default: next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      req <= '0;
      ctxIrqPrev <= 4'h0;
      rxEvent <= IRX_EVT_RST;
      mask <= IRX_MSK_RST;
      globalInterruptEnable <= IRX_GIE_RST;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      aggregateReceiveInterrupt <= 1'b0;
      irq <= 1'b0;
    end else begin
      req <= next_req;
      ctxIrqPrev <= ctxIrq;
      rxEvent <= next_rxEvent;
      mask <= next_mask;
      globalInterruptEnable <= next_gie;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      aggregateReceiveInterrupt <= next_agg;
      irq <= next_irq;
    end
  end

  // Hardware edges set events one cycle later
  a_event_rise: assert property (@(posedge ref_clk) disable iff (rst)
    ctxRise[0] |=> rxEvent[0])
    else $error("context 0 edge did not set event");
  a_event_rise1: assert property (@(posedge ref_clk) disable iff (rst)
    ctxRise[1] |=> rxEvent[1])
    else $error("context 1 edge did not set event");
  a_event_rise2: assert property (@(posedge ref_clk) disable iff (rst)
    ctxRise[2] |=> rxEvent[2])
    else $error("context 2 edge did not set event");
  a_event_rise3: assert property (@(posedge ref_clk) disable iff (rst)
    ctxRise[3] |=> rxEvent[3])
    else $error("context 3 edge did not set event");

  // Events survive everything but a clear write
  a_event_sticky: assert property (@(posedge ref_clk) disable iff (rst)
    (rxEvent[1] && !wrEvtClr) |=> rxEvent[1])
    else $error("event dropped");
  a_event_sticky0: assert property (@(posedge ref_clk) disable iff (rst)
    (rxEvent[0] && !wrEvtClr) |=> rxEvent[0])
    else $error("event 0 dropped");
  a_event_sticky2: assert property (@(posedge ref_clk) disable iff (rst)
    (rxEvent[2] && !wrEvtClr) |=> rxEvent[2])
    else $error("event 2 dropped");
  a_event_sticky3: assert property (@(posedge ref_clk) disable iff (rst)
    (rxEvent[3] && !wrEvtClr) |=> rxEvent[3])
    else $error("event 3 dropped");
  a_event_hold: assert property (@(posedge ref_clk) disable iff (rst)
    (!wrEvtSet && !wrEvtClr && ctxRise == 4'h0) |=> rxEvent == $past(rxEvent))
    else $error("event changed with no cause");

  // Write-one clear, unless a hardware edge lands in the same cycle
  a_event_clear: assert property (@(posedge ref_clk) disable iff (rst)
    (wrEvtClr && hwdata[2] && !ctxRise[2] && !wrEvtSet) |=> !rxEvent[2])
    else $error("event clear failed");
  a_event_clear0: assert property (@(posedge ref_clk) disable iff (rst)
    (wrEvtClr && hwdata[0] && !ctxRise[0]) |=> !rxEvent[0])
    else $error("event 0 clear failed");
  a_event_clear1: assert property (@(posedge ref_clk) disable iff (rst)
    (wrEvtClr && hwdata[1] && !ctxRise[1]) |=> !rxEvent[1])
    else $error("event 1 clear failed");
  a_event_clear3: assert property (@(posedge ref_clk) disable iff (rst)
    (wrEvtClr && hwdata[3] && !ctxRise[3]) |=> !rxEvent[3])
    else $error("event 3 clear failed");

  // Software set path
  a_soft_set: assert property (@(posedge ref_clk) disable iff (rst)
    (wrEvtSet && hwdata[3]) |=> rxEvent[3])
    else $error("soft set failed");
  a_soft_set0: assert property (@(posedge ref_clk) disable iff (rst)
    (wrEvtSet && hwdata[0]) |=> rxEvent[0])
    else $error("soft set 0 failed");
  a_soft_set1: assert property (@(posedge ref_clk) disable iff (rst)
    (wrEvtSet && hwdata[1]) |=> rxEvent[1])
    else $error("soft set 1 failed");
  a_soft_set2: assert property (@(posedge ref_clk) disable iff (rst)
    (wrEvtSet && hwdata[2]) |=> rxEvent[2])
    else $error("soft set 2 failed");

  // A steady high level must not set again; only an edge or a write does
  a_no_spont0: assert property (@(posedge ref_clk) disable iff (rst)
    (!rxEvent[0] && !ctxRise[0] && !(wrEvtSet && hwdata[0])) |=> !rxEvent[0])
    else $error("event 0 set with no cause");
  a_no_spont1: assert property (@(posedge ref_clk) disable iff (rst)
    (!rxEvent[1] && !ctxRise[1] && !(wrEvtSet && hwdata[1])) |=> !rxEvent[1])
    else $error("event 1 set with no cause");
  a_no_spont2: assert property (@(posedge ref_clk) disable iff (rst)
    (!rxEvent[2] && !ctxRise[2] && !(wrEvtSet && hwdata[2])) |=> !rxEvent[2])
    else $error("event 2 set with no cause");
  a_no_spont3: assert property (@(posedge ref_clk) disable iff (rst)
    (!rxEvent[3] && !ctxRise[3] && !(wrEvtSet && hwdata[3])) |=> !rxEvent[3])
    else $error("event 3 set with no cause");

  // Mask set, clear and hold
  a_mask_set: assert property (@(posedge ref_clk) disable iff (rst)
    (wrMskSet && hwdata[0] && !wrMskClr) |=> mask[0])
    else $error("mask set failed");
  a_mask_set1: assert property (@(posedge ref_clk) disable iff (rst)
    (wrMskSet && hwdata[1]) |=> mask[1])
    else $error("mask 1 set failed");
  a_mask_set2: assert property (@(posedge ref_clk) disable iff (rst)
    (wrMskSet && hwdata[2]) |=> mask[2])
    else $error("mask 2 set failed");
  a_mask_set3: assert property (@(posedge ref_clk) disable iff (rst)
    (wrMskSet && hwdata[3]) |=> mask[3])
    else $error("mask 3 set failed");
  a_mask_clear: assert property (@(posedge ref_clk) disable iff (rst)
    (wrMskClr && hwdata[1]) |=> !mask[1])
    else $error("mask clear failed");
  a_mask_clear0: assert property (@(posedge ref_clk) disable iff (rst)
    (wrMskClr && hwdata[0]) |=> !mask[0])
    else $error("mask 0 clear failed");
  a_mask_clear2: assert property (@(posedge ref_clk) disable iff (rst)
    (wrMskClr && hwdata[2]) |=> !mask[2])
    else $error("mask 2 clear failed");
  a_mask_clear3: assert property (@(posedge ref_clk) disable iff (rst)
    (wrMskClr && hwdata[3]) |=> !mask[3])
    else $error("mask 3 clear failed");
  a_mask_hold: assert property (@(posedge ref_clk) disable iff (rst)
    (!wrMskSet && !wrMskClr) |=> mask == $past(mask))
    else $error("mask changed with no write");

  // Aggregate and gated interrupt levels
  a_agg_value: assert property (@(posedge ref_clk) disable iff (rst)
    ##1 aggregateReceiveInterrupt == |(rxEvent & mask))
    else $error("aggregate wrong");
  a_src_ctx0: assert property (@(posedge ref_clk) disable iff (rst)
    (rxEvent[0] && mask[0]) |-> aggregateReceiveInterrupt)
    else $error("context 0 not reported");
  a_src_ctx1: assert property (@(posedge ref_clk) disable iff (rst)
    (rxEvent[1] && mask[1]) |-> aggregateReceiveInterrupt)
    else $error("context 1 not reported");
  a_src_ctx2: assert property (@(posedge ref_clk) disable iff (rst)
    (rxEvent[2] && mask[2]) |-> aggregateReceiveInterrupt)
    else $error("context 2 not reported");
  a_src_ctx3: assert property (@(posedge ref_clk) disable iff (rst)
    (rxEvent[3] && mask[3]) |-> aggregateReceiveInterrupt)
    else $error("context 3 not reported");
  a_agg_masked: assert property (@(posedge ref_clk) disable iff (rst)
    ((rxEvent & mask) == 4'h0) |-> !aggregateReceiveInterrupt)
    else $error("aggregate without enabled event");
  a_gie_gate: assert property (@(posedge ref_clk) disable iff (rst)
    !globalInterruptEnable |-> !irq)
    else $error("irq without enable");
  a_irq_value: assert property (@(posedge ref_clk) disable iff (rst)
    irq == (aggregateReceiveInterrupt && globalInterruptEnable))
    else $error("irq level wrong");
  a_gie_write: assert property (@(posedge ref_clk) disable iff (rst)
    wrGie |=> globalInterruptEnable == $past(hwdata[31]))
    else $error("enable write failed");
  a_gie_hold: assert property (@(posedge ref_clk) disable iff (rst)
    !wrGie |=> globalInterruptEnable == $past(globalInterruptEnable))
    else $error("enable changed with no write");

  // Read data in the data phase
  a_rsvd_zero: assert property (@(posedge ref_clk) disable iff (rst)
    $past(next_req.sel && next_req.addr == IRX_EVT_SET_OFS) |-> hrdata[31:4] == 28'h0)
    else $error("reserved bits nonzero");
  a_event_read: assert property (@(posedge ref_clk) disable iff (rst)
    (next_req.sel && !next_req.write && next_req.addr == IRX_EVT_SET_OFS)
    |=> hrdata == {28'h0, rxEvent}) else $error("event read wrong");
  a_clear_read: assert property (@(posedge ref_clk) disable iff (rst)
    (next_req.sel && !next_req.write && next_req.addr == IRX_EVT_CLR_OFS)
    |=> hrdata == {20'h0, mask, 4'h0, rxEvent}) else $error("clear read wrong");
  a_mask_read: assert property (@(posedge ref_clk) disable iff (rst)
    (next_req.sel && !next_req.write && next_req.addr == IRX_MSK_SET_OFS)
    |=> hrdata[3:0] == mask) else $error("mask read wrong");
  a_mskclr_read: assert property (@(posedge ref_clk) disable iff (rst)
    (next_req.sel && !next_req.write && next_req.addr == IRX_MSK_CLR_OFS)
    |=> hrdata == {28'h0, mask}) else $error("mask clear read wrong");
  a_gie_read: assert property (@(posedge ref_clk) disable iff (rst)
    (next_req.sel && !next_req.write && next_req.addr == IRX_GIE_OFS)
    |=> hrdata == {globalInterruptEnable, 31'h0}) else $error("enable read wrong");
  a_idle_read: assert property (@(posedge ref_clk) disable iff (rst)
    !(next_req.sel && !next_req.write) |=> hrdata == 32'h0000_0000)
    else $error("read data outside a read");
  a_unmapped_read: assert property (@(posedge ref_clk) disable iff (rst)
    (next_req.sel && !next_req.write && next_req.addr != IRX_EVT_SET_OFS
    && next_req.addr != IRX_EVT_CLR_OFS && next_req.addr != IRX_MSK_SET_OFS
    && next_req.addr != IRX_MSK_CLR_OFS && next_req.addr != IRX_GIE_OFS)
    |=> hrdata == 32'h0000_0000) else $error("unmapped read nonzero");

  // Zero wait states and always OKAY; the bench relies on both
  a_ready_high: assert property (@(posedge ref_clk) disable iff (rst)
    hreadyout)
    else $error("wait state inserted");
  a_resp_okay: assert property (@(posedge ref_clk) disable iff (rst)
    !hresp)
    else $error("error response");
  a_irq_agg: assert property (@(posedge ref_clk) disable iff (rst)
    irq |-> aggregateReceiveInterrupt)
    else $error("irq without aggregate");

endmodule

`default_nettype wire

/* core/irx_pkg.sv */
// Package for the isochronous receive interrupt block: offsets, layouts, types
package irx_pkg;
  localparam int IRX_CTX = 4;
  localparam logic [7:0] IRX_EVT_SET_OFS = 8'hA0;
  localparam logic [7:0] IRX_EVT_CLR_OFS = 8'hA4;
  localparam logic [7:0] IRX_MSK_SET_OFS = 8'hA8;
  localparam logic [7:0] IRX_MSK_CLR_OFS = 8'hAC;
  localparam logic [7:0] IRX_GIE_OFS = 8'hB0;
  localparam logic [3:0] IRX_EVT_RST = 4'h0;
  localparam logic [3:0] IRX_MSK_RST = 4'h0;
  localparam logic IRX_GIE_RST = 1'b0;
  localparam int IRX_GIE_BIT = 31;
  localparam int IRX_MSK_RD_LSB = 8;
  localparam logic [1:0] IRX_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] IRX_HSIZE_WORD = 3'h2;

  typedef struct packed {
    logic sel;
    logic write;
    logic [7:0] addr;
  } irx_req_t;
endpackage

/* bench/tb_top.sv */
// Self-checking bench for the receive interrupt event and mask registers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import irx_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, hwrite = 1'b0, hreadyout, hresp, agg, irq;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [3:0] ctxIrq = 4'h0;
  int errorCnt = 0, nChecks = 0;
  irx_regs irx_regs_i (.ref_clk(ref_clk), .rst(rst), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(IRX_HSIZE_WORD), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ctxIrq(ctxIrq), .aggregateReceiveInterrupt(agg), .irq(irq));
  initial forever #50 ref_clk = ~ref_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Leading edge keeps back-to-back calls from driving htrans twice at once
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge ref_clk);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= IRX_HTRANS_NONSEQ;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(a, 1'b1, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(a, 1'b0, 32'h0, r);
    chk(r, exp);
    chk({30'h0, hreadyout, hresp}, 32'h00000002);
  endtask
  // Outputs sampled mid-cycle, after the write edge has settled
  task automatic ck(input logic [1:0] exp);
    @(negedge ref_clk);
    chk({30'h0, agg, irq}, {30'h0, exp});
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", nChecks, errorCnt);
    if (errorCnt == 0 && nChecks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    rd(IRX_EVT_SET_OFS, 32'h0);
    rd(IRX_MSK_SET_OFS, 32'h0);
    $display("test reset done");
    wr(IRX_EVT_SET_OFS, 32'hFFFFFFF5);
    rd(IRX_EVT_SET_OFS, 32'h00000005);
    ck(2'b00);
    wr(IRX_MSK_SET_OFS, 32'h00000004);
    rd(IRX_MSK_CLR_OFS, 32'h00000004);
    ck(2'b10);
    rd(IRX_EVT_CLR_OFS, 32'h00000405);
    wr(IRX_GIE_OFS, 32'h80000000);
    ck(2'b11);
    wr(IRX_EVT_CLR_OFS, 32'h00000000);
    rd(IRX_EVT_SET_OFS, 32'h00000005);
    wr(IRX_EVT_CLR_OFS, 32'h00000004);
    rd(IRX_EVT_SET_OFS, 32'h00000001);
    ck(2'b00);
    $display("test software set and clear done");
    @(posedge ref_clk);
    ctxIrq <= 4'hA;
    repeat (2) @(posedge ref_clk);
    rd(IRX_EVT_SET_OFS, 32'h0000000B);
    wr(IRX_MSK_SET_OFS, 32'h00000008);
    ck(2'b11);
    // Level still high: an edge-only set must not come back
    wr(IRX_EVT_CLR_OFS, 32'h0000000F);
    rd(IRX_EVT_SET_OFS, 32'h0);
    ck(2'b00);
    wr(IRX_MSK_CLR_OFS, 32'h0000000C);
    rd(IRX_MSK_SET_OFS, 32'h0);
    rd(8'h10, 32'h0);
    $display("test hardware events done");
    ctxIrq <= 4'h0;
    wr(IRX_EVT_SET_OFS, 32'h00000006);
    wr(IRX_MSK_SET_OFS, 32'h00000002);
    ck(2'b11);
    wr(IRX_GIE_OFS, 32'h00000000);
    ck(2'b10);
    rd(IRX_GIE_OFS, 32'h0);
    $display("test global enable done");
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    ck(2'b00);
    rd(IRX_EVT_SET_OFS, 32'h0);
    rd(IRX_MSK_SET_OFS, 32'h0);
    rd(IRX_GIE_OFS, 32'h0);
    $display("test mid-run reset done");
    stop_test();
  end
  initial begin
    repeat (2000) @(posedge ref_clk);
    errorCnt++;
    stop_test();
  end
endmodule
`default_nettype wire
